// ===== joint_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
module joint_drive_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// commands
	input wire logic signed [15:0] i_vel,
	input wire logic i_load,
	input wire logic signed [31:0] i_load_value,
	input wire logic i_unlock,
	input wire logic i_slow,
	// sensed state
	output logic o_home_sw,
	output logic o_index,
	output logic o_stopped,
	output logic o_unlocked,
	output logic signed [31:0] o_pos
);
	int phys = 0;
	int ofs = 0;
	int still = 0;
	int held = 0;
	// physical travel is kept apart from the loaded coordinate
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ofs <= 0;
			still <= 0;
			held <= 0;
		end else begin
			if (i_load)
				ofs <= i_load_value - phys;
			phys <= phys + int'(i_vel);
			still <= (i_vel == 16'sh0) ? still + 1 : 0;
			held <= i_unlock ? held + 1 : 0;
		end
	end
	assign o_home_sw = phys >= 600 && phys <= 900;
	assign o_index = phys[7:5] == 3'h4;
	assign o_stopped = still >= (i_slow ? 6 : 1);
	assign o_unlocked = held >= (i_slow ? 5 : 2);
	assign o_pos = phys + ofs;
endmodule
`default_nettype wire

// ===== joint_homing_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module joint_homing_monitor #(
	parameter int VEL_W = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// bus
	input wire logic i_read,
	input wire logic i_write,
	input wire logic o_waitrequest,
	// homing outputs
	input wire logic signed [VEL_W-1:0] o_vel_cmd,
	input wire logic o_pos_load,
	input wire logic o_limit_masked,
	input wire logic o_unlock,
	input wire logic o_homing,
	input wire logic o_homed,
	input wire logic o_error
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	// three cycles at rest covers the lag of the homing flag
	sequence s_idle3;
		(!o_homing) [*3];
	endsequence
	sequence s_homed_up;
		$rose(o_homed);
	endsequence
	property p_load_pulse;
		o_pos_load |=> !o_pos_load;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("position load wider than one cycle");
	property p_load_unhomed;
		o_pos_load |-> !o_homed;
	endproperty
	a_load_unhomed: assert property (p_load_unhomed) else $error("homed before the latch");
	property p_homed_clean;
		s_homed_up |-> !o_error && o_vel_cmd == '0;
	endproperty
	a_homed_clean: assert property (p_homed_clean) else $error("homed while moving or in error");
	property p_idle_vel;
		s_idle3 |-> o_vel_cmd == '0;
	endproperty
	a_idle_vel: assert property (p_idle_vel) else $error("velocity while idle");
	property p_idle_mask;
		s_idle3 |-> !o_limit_masked;
	endproperty
	a_idle_mask: assert property (p_idle_mask) else $error("limit masked while idle");
	property p_idle_lock;
		s_idle3 |-> !o_unlock;
	endproperty
	a_idle_lock: assert property (p_idle_lock) else $error("indexer left unlocked");
	property p_err_stop;
		$rose(o_error) |-> ##[1:4] !o_homing;
	endproperty
	a_err_stop: assert property (p_err_stop) else $error("run not aborted on error");
	property p_wait_one;
		!o_waitrequest |=> o_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	property p_wait_cause;
		!o_waitrequest |-> $past(i_read || i_write);
	endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("waitrequest low without request");
endmodule
bind joint_homing_sequencer joint_homing_monitor #(.VEL_W(VEL_W)) mon (
	.i_clk(i_clk),
	.i_resetn(i_resetn),
	.i_read(i_read),
	.i_write(i_write),
	.o_waitrequest(o_waitrequest),
	.o_vel_cmd(o_vel_cmd),
	.o_pos_load(o_pos_load),
	.o_limit_masked(o_limit_masked),
	.o_unlock(o_unlock),
	.o_homing(o_homing),
	.o_homed(o_homed),
	.o_error(o_error)
);
`default_nettype wire

// ===== joint_homing_pkg.sv
// How it works
// - pick immediate, index-only, switch-only or switch-plus-index from the settings
// - any other velocity and index combination is a configuration error, no run
// - zero seek velocity means no home switch, so the search is skipped
// - switch already active at start: move off it opposite the seek sign
// - search along the seek velocity, stop as soon as the switch is seen
// - same signs: back off the switch, then approach again at capture velocity
// - opposite signs: capture moves away, first qualifying edge after leaving switch
// - seek zero, capture nonzero, index used: go straight to index search at capture velocity
// - seek nonzero, capture zero: flag an error and abort
// - index used: latch index rising edge; else switch edge chosen by signs
// - at the latch point load the joint coordinate with the home offset
// - last step moves the joint from the offset point to the home position
// - final move uses final velocity, or maximum joint speed when that is zero
// - a final move is always issued except for the immediate homing type
// - ignore-limits masks only this joint's limit while homing; default off
// - shared switch guard set: refuse to start while the home switch is closed
// - home-all start waits until all lower sequence joints are homed
// - sequence number -1 keeps the joint out of home-all
// - unhome-on-off set: homed clears when the machine turns off
// - locking indexer: unlock before homing, lock after it completes
`default_nettype none
package joint_homing_pkg;
	// register word addresses
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_CFG = 4'h1;
	localparam logic [3:0] REG_SEEK_VEL = 4'h2;
	localparam logic [3:0] REG_CAPTURE_VEL = 4'h3;
	localparam logic [3:0] REG_FINAL_VEL = 4'h4;
	localparam logic [3:0] REG_MAX_VEL = 4'h5;
	localparam logic [3:0] REG_HOME_OFFSET = 4'h6;
	localparam logic [3:0] REG_HOME_POS = 4'h7;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// control bits (write-one pulses)
	localparam int CTRL_START = 0;
	localparam int CTRL_ABORT = 1;
	// configuration bits
	localparam int CFG_USE_INDEX = 0;
	localparam int CFG_IGNORE_LIMITS = 1;
	localparam int CFG_SHARED_GUARD = 2;
	localparam int CFG_UNHOME_ON_OFF = 3;
	localparam int CFG_LOCKING = 4;
	localparam int CFG_SEQ_LSB = 8;
	localparam int SEQ_W = 8;
	localparam logic [SEQ_W-1:0] SEQ_RESET = 8'hff;
	// status bits
	localparam int ST_HOMED = 0;
	localparam int ST_HOMING = 1;
	localparam int ST_CFG_ERR = 2;
	localparam int ST_LIMIT_ERR = 3;
	localparam int ST_SHARED_ERR = 4;
	localparam int ST_ARMED = 5;
	localparam int ST_UNLOCK = 6;
	// synchronised pin inputs
	localparam int PIN_HOME_SW = 0;
	localparam int PIN_INDEX = 1;
	localparam int PIN_LIMIT = 2;
	localparam int PIN_MACHINE_ON = 3;
	localparam int PIN_STOPPED = 4;
	localparam int PIN_UNLOCKED = 5;
	localparam int PIN_N = 6;
	typedef enum logic [1:0] {
		TYPE_IMMEDIATE,
		TYPE_INDEX_ONLY,
		TYPE_SWITCH,
		TYPE_INVALID
	} home_type_e;
endpackage
`default_nettype wire

// ===== joint_homing_sequencer.sv
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module joint_homing_sequencer #(
	parameter int VEL_W = 16,
	parameter int POS_W = 32
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// avalon-mm slave
	input wire logic [joint_homing_pkg::ADDR_W-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [joint_homing_pkg::DATA_W-1:0] i_writedata,
	output logic [joint_homing_pkg::DATA_W-1:0] o_readdata,
	output logic o_waitrequest,
	// joint pins
	input wire logic i_home_sw,
	input wire logic i_index,
	input wire logic i_limit,
	input wire logic i_machine_on,
	input wire logic i_stopped,
	input wire logic i_unlocked,
	input wire logic signed [POS_W-1:0] i_joint_pos,
	// home-all coordination
	input wire logic i_home_all,
	input wire logic i_lower_homed,
	// drive side
	output logic signed [VEL_W-1:0] o_vel_cmd,
	output logic o_pos_load,
	output logic signed [POS_W-1:0] o_pos_load_value,
	output logic o_limit_masked,
	output logic o_unlock,
	output logic o_homing,
	output logic o_homed,
	output logic o_error
);
	if (VEL_W < 2 || VEL_W > 32 || POS_W < VEL_W || POS_W > 32) begin : g_bad_width
		$error("joint_homing_sequencer: unsupported VEL_W or POS_W");
	end

	typedef enum logic [3:0] {
		S_IDLE,
		S_UNLOCK,
		S_CHECK,
		S_CLEAR,
		S_SEARCH,
		S_BACKOFF,
		S_LATCH,
		S_LOADWAIT,
		S_FINAL,
		S_STOPWAIT,
		S_LOCK
	} state_e;

	state_e state;
	state_e stop_next;

	// pin synchronisers
	logic [joint_homing_pkg::PIN_N-1:0] pin_meta;
	logic [joint_homing_pkg::PIN_N-1:0] pin_sync;
	logic home_sw_d;
	logic index_d;
	logic machine_on_d;

	// configuration
	logic signed [VEL_W-1:0] seek_vel;
	logic signed [VEL_W-1:0] capture_vel;
	logic signed [VEL_W-1:0] final_vel;
	logic signed [VEL_W-1:0] max_vel;
	logic signed [POS_W-1:0] home_offset;
	logic signed [POS_W-1:0] home_pos;
	logic use_index;
	logic ignore_limits;
	logic shared_guard;
	logic unhome_on_off;
	logic locking;
	logic signed [joint_homing_pkg::SEQ_W-1:0] home_seq;

	// status
	logic cfg_err;
	logic limit_err;
	logic shared_err;
	logic armed;
	logic qualified;
	logic final_up;

	// bus strobes
	logic bus_take;
	logic wr_start;
	logic wr_abort;

	logic sw;
	logic sw_rise;
	logic sw_fall;
	logic idx_rise;
	logic off_edge;
	logic start;
	logic abort;
	logic same_sign;
	logic latch_hit;
	logic seek_zero;
	logic cap_zero;
	logic signed [VEL_W-1:0] final_speed;
	joint_homing_pkg::home_type_e home_type;

	function automatic logic signed [VEL_W-1:0] negate(input logic signed [VEL_W-1:0] v);
		negate = VEL_W'(-v);
	endfunction

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {i_unlocked, i_stopped, i_machine_on, i_limit, i_index, i_home_sw};
			pin_sync <= pin_meta;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			home_sw_d <= 1'b0;
			index_d <= 1'b0;
			machine_on_d <= 1'b0;
		end else begin
			home_sw_d <= pin_sync[joint_homing_pkg::PIN_HOME_SW];
			index_d <= pin_sync[joint_homing_pkg::PIN_INDEX];
			machine_on_d <= pin_sync[joint_homing_pkg::PIN_MACHINE_ON];
		end
	end

	assign sw = pin_sync[joint_homing_pkg::PIN_HOME_SW];
	assign sw_rise = sw && !home_sw_d;
	assign sw_fall = !sw && home_sw_d;
	assign idx_rise = pin_sync[joint_homing_pkg::PIN_INDEX] && !index_d;
	assign off_edge = machine_on_d && !pin_sync[joint_homing_pkg::PIN_MACHINE_ON];

	// homing type decode
	assign seek_zero = (seek_vel == '0);
	assign cap_zero = (capture_vel == '0);
	assign same_sign = (seek_vel[VEL_W-1] == capture_vel[VEL_W-1]);

	always_comb begin
		if (seek_zero && cap_zero && !use_index) begin
			home_type = joint_homing_pkg::TYPE_IMMEDIATE;
		end else if (seek_zero && !cap_zero && use_index) begin
			home_type = joint_homing_pkg::TYPE_INDEX_ONLY;
		end else if (!seek_zero && !cap_zero) begin
			home_type = joint_homing_pkg::TYPE_SWITCH;
		end else begin
			home_type = joint_homing_pkg::TYPE_INVALID;
		end
	end

	// qualifying latch event
	always_comb begin
		if (use_index) begin
			latch_hit = qualified && idx_rise;
		end else if (same_sign) begin
			latch_hit = sw_rise;
		end else begin
			latch_hit = sw_fall;
		end
	end

	assign final_speed = (final_vel == '0) ? max_vel : final_vel;

	// avalon slave: one wait cycle, then the accepting edge
	assign bus_take = (i_read || i_write) && !o_waitrequest;
	assign wr_start = bus_take && i_write && (i_address == joint_homing_pkg::REG_CTRL)
		&& i_writedata[joint_homing_pkg::CTRL_START];
	assign wr_abort = bus_take && i_write && (i_address == joint_homing_pkg::REG_CTRL)
		&& i_writedata[joint_homing_pkg::CTRL_ABORT];

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_waitrequest <= 1'b1;
		end else if (bus_take) begin
			o_waitrequest <= 1'b1;
		end else if (i_read || i_write) begin
			o_waitrequest <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_readdata <= '0;
		end else if (i_read && o_waitrequest) begin
			o_readdata <= '0;
			unique case (i_address)
				joint_homing_pkg::REG_CFG: begin
					o_readdata[joint_homing_pkg::CFG_USE_INDEX] <= use_index;
					o_readdata[joint_homing_pkg::CFG_IGNORE_LIMITS] <= ignore_limits;
					o_readdata[joint_homing_pkg::CFG_SHARED_GUARD] <= shared_guard;
					o_readdata[joint_homing_pkg::CFG_UNHOME_ON_OFF] <= unhome_on_off;
					o_readdata[joint_homing_pkg::CFG_LOCKING] <= locking;
					o_readdata[joint_homing_pkg::CFG_SEQ_LSB +: joint_homing_pkg::SEQ_W] <= home_seq;
				end
				joint_homing_pkg::REG_SEEK_VEL: o_readdata <= 32'(seek_vel);
				joint_homing_pkg::REG_CAPTURE_VEL: o_readdata <= 32'(capture_vel);
				joint_homing_pkg::REG_FINAL_VEL: o_readdata <= 32'(final_vel);
				joint_homing_pkg::REG_MAX_VEL: o_readdata <= 32'(max_vel);
				joint_homing_pkg::REG_HOME_OFFSET: o_readdata <= 32'(home_offset);
				joint_homing_pkg::REG_HOME_POS: o_readdata <= 32'(home_pos);
				joint_homing_pkg::REG_STATUS: begin
					o_readdata[joint_homing_pkg::ST_HOMED] <= o_homed;
					o_readdata[joint_homing_pkg::ST_HOMING] <= o_homing;
					o_readdata[joint_homing_pkg::ST_CFG_ERR] <= cfg_err;
					o_readdata[joint_homing_pkg::ST_LIMIT_ERR] <= limit_err;
					o_readdata[joint_homing_pkg::ST_SHARED_ERR] <= shared_err;
					o_readdata[joint_homing_pkg::ST_ARMED] <= armed;
					o_readdata[joint_homing_pkg::ST_UNLOCK] <= o_unlock;
				end
				default: o_readdata <= '0;
			endcase
		end
	end

	// configuration registers
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			seek_vel <= '0;
			capture_vel <= '0;
			final_vel <= '0;
			max_vel <= '0;
			home_offset <= '0;
			home_pos <= '0;
			use_index <= 1'b0;
			ignore_limits <= 1'b0;
			shared_guard <= 1'b0;
			unhome_on_off <= 1'b0;
			locking <= 1'b0;
			home_seq <= joint_homing_pkg::SEQ_RESET;
		end else if (bus_take && i_write) begin
			unique case (i_address)
				joint_homing_pkg::REG_CFG: begin
					use_index <= i_writedata[joint_homing_pkg::CFG_USE_INDEX];
					ignore_limits <= i_writedata[joint_homing_pkg::CFG_IGNORE_LIMITS];
					shared_guard <= i_writedata[joint_homing_pkg::CFG_SHARED_GUARD];
					unhome_on_off <= i_writedata[joint_homing_pkg::CFG_UNHOME_ON_OFF];
					locking <= i_writedata[joint_homing_pkg::CFG_LOCKING];
					home_seq <= i_writedata[joint_homing_pkg::CFG_SEQ_LSB +: joint_homing_pkg::SEQ_W];
				end
				joint_homing_pkg::REG_SEEK_VEL: seek_vel <= i_writedata[VEL_W-1:0];
				joint_homing_pkg::REG_CAPTURE_VEL: capture_vel <= i_writedata[VEL_W-1:0];
				joint_homing_pkg::REG_FINAL_VEL: final_vel <= i_writedata[VEL_W-1:0];
				joint_homing_pkg::REG_MAX_VEL: max_vel <= i_writedata[VEL_W-1:0];
				joint_homing_pkg::REG_HOME_OFFSET: home_offset <= i_writedata[POS_W-1:0];
				joint_homing_pkg::REG_HOME_POS: home_pos <= i_writedata[POS_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// home-all arming; negative sequence numbers never arm
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			armed <= 1'b0;
		end else if (state != S_IDLE || wr_abort) begin
			armed <= 1'b0;
		end else if (i_home_all && !home_seq[joint_homing_pkg::SEQ_W-1]) begin
			armed <= 1'b1;
		end else if (armed && i_lower_homed) begin
			armed <= 1'b0;
		end
	end

	assign start = (state == S_IDLE) && (wr_start || (armed && i_lower_homed));
	assign abort = (state != S_IDLE) && (wr_abort || !pin_sync[joint_homing_pkg::PIN_MACHINE_ON]
		|| (pin_sync[joint_homing_pkg::PIN_LIMIT] && !ignore_limits));

	// main sequencer
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= S_IDLE;
			stop_next <= S_IDLE;
			o_vel_cmd <= '0;
			o_pos_load <= 1'b0;
			o_pos_load_value <= '0;
			o_unlock <= 1'b0;
			cfg_err <= 1'b0;
			limit_err <= 1'b0;
			shared_err <= 1'b0;
			qualified <= 1'b0;
			final_up <= 1'b0;
		end else begin
			o_pos_load <= 1'b0;
			if (abort) begin
				state <= S_IDLE;
				o_vel_cmd <= '0;
				o_unlock <= 1'b0;
				limit_err <= pin_sync[joint_homing_pkg::PIN_LIMIT] && !ignore_limits;
			end else begin
				unique case (state)
					S_IDLE: begin
						if (start) begin
							cfg_err <= 1'b0;
							limit_err <= 1'b0;
							shared_err <= 1'b0;
							if (shared_guard && sw) begin
								shared_err <= 1'b1;
							end else if (locking) begin
								state <= S_UNLOCK;
							end else begin
								state <= S_CHECK;
							end
						end
					end
					S_UNLOCK: begin
						// raised one cycle after start so it never leads the homing flag
						o_unlock <= 1'b1;
						if (pin_sync[joint_homing_pkg::PIN_UNLOCKED]) begin
							state <= S_CHECK;
						end
					end
					S_CHECK: begin
						qualified <= 1'b0;
						unique case (home_type)
							joint_homing_pkg::TYPE_IMMEDIATE: begin
								o_pos_load <= 1'b1;
								o_pos_load_value <= home_offset;
								state <= S_LOADWAIT;
							end
							joint_homing_pkg::TYPE_INDEX_ONLY: begin
								qualified <= 1'b1;
								o_vel_cmd <= capture_vel;
								state <= S_LATCH;
							end
							joint_homing_pkg::TYPE_SWITCH: begin
								if (sw) begin
									o_vel_cmd <= negate(seek_vel);
									state <= S_CLEAR;
								end else begin
									o_vel_cmd <= seek_vel;
									state <= S_SEARCH;
								end
							end
							default: begin
								cfg_err <= 1'b1;
								o_unlock <= 1'b0;
								state <= S_IDLE;
							end
						endcase
					end
					S_CLEAR: begin
						if (!sw) begin
							o_vel_cmd <= seek_vel;
							state <= S_SEARCH;
						end
					end
					S_SEARCH: begin
						if (sw) begin
							o_vel_cmd <= '0;
							stop_next <= same_sign ? S_BACKOFF : S_LATCH;
							state <= S_STOPWAIT;
						end
					end
					S_BACKOFF: begin
						o_vel_cmd <= negate(seek_vel);
						if (!sw) begin
							o_vel_cmd <= '0;
							stop_next <= S_LATCH;
							state <= S_STOPWAIT;
						end
					end
					S_LATCH: begin
						o_vel_cmd <= capture_vel;
						if (same_sign && sw) begin
							qualified <= 1'b1;
						end else if (!same_sign && !sw) begin
							qualified <= 1'b1;
						end
						if (home_type == joint_homing_pkg::TYPE_INDEX_ONLY) begin
							qualified <= 1'b1;
						end
						if (latch_hit) begin
							o_vel_cmd <= '0;
							o_pos_load <= 1'b1;
							o_pos_load_value <= home_offset;
							state <= S_LOADWAIT;
						end
					end
					S_LOADWAIT: begin
						if (home_type == joint_homing_pkg::TYPE_IMMEDIATE) begin
							state <= locking ? S_LOCK : S_IDLE;
							o_unlock <= 1'b0;
						end else begin
							stop_next <= S_FINAL;
							state <= S_STOPWAIT;
						end
					end
					S_STOPWAIT: begin
						if (pin_sync[joint_homing_pkg::PIN_STOPPED]) begin
							state <= stop_next;
							if (stop_next == S_FINAL) begin
								final_up <= (home_pos >= i_joint_pos);
								o_vel_cmd <= (home_pos >= i_joint_pos) ? final_speed : negate(final_speed);
							end else if (stop_next == S_LOCK) begin
								o_unlock <= 1'b0;
							end
						end
					end
					S_FINAL: begin
						if (final_up ? (i_joint_pos >= home_pos) : (i_joint_pos <= home_pos)) begin
							o_vel_cmd <= '0;
							stop_next <= locking ? S_LOCK : S_IDLE;
							if (!locking) begin
								o_unlock <= 1'b0;
							end
							state <= S_STOPWAIT;
						end
					end
					S_LOCK: begin
						if (!pin_sync[joint_homing_pkg::PIN_UNLOCKED]) begin
							state <= S_IDLE;
						end
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	// homed flag: completion sets it, restart or machine-off with unhome_on_off set clears it; set wins
	logic homing_done;
	assign homing_done = !abort && ((state == S_LOCK && !pin_sync[joint_homing_pkg::PIN_UNLOCKED])
		|| (state == S_LOADWAIT && home_type == joint_homing_pkg::TYPE_IMMEDIATE && !locking)
		|| (state == S_STOPWAIT && stop_next == S_IDLE && pin_sync[joint_homing_pkg::PIN_STOPPED]));

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_homed <= 1'b0;
		end else if (homing_done) begin
			o_homed <= 1'b1;
		end else if (start && !(shared_guard && sw)) begin
			o_homed <= 1'b0;
		end else if (off_edge && unhome_on_off) begin
			o_homed <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_homing <= 1'b0;
			o_limit_masked <= 1'b0;
			o_error <= 1'b0;
		end else begin
			o_homing <= (state != S_IDLE);
			o_limit_masked <= (state != S_IDLE) && ignore_limits;
			o_error <= cfg_err || limit_err || shared_err;
		end
	end
endmodule
`default_nettype wire

// ===== joint_homing_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module joint_homing_sequencer_tb_top;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [3:0] i_address = 4'h0;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = 32'h0;
	logic i_limit = 1'b0;
	logic i_machine_on = 1'b1;
	logic i_home_all = 1'b0;
	logic i_lower_homed = 1'b0;
	logic slow = 1'b0;
	logic [31:0] o_readdata;
	logic o_waitrequest, home_sw, index, stopped, unlocked, o_pos_load, o_limit_masked, o_unlock;
	logic o_homing, o_homed, o_error;
	logic signed [31:0] joint_pos, o_pos_load_value;
	logic signed [15:0] o_vel_cmd;
	logic [31:0] ld, rd, qg[$], qe[$];
	int n_errors = 0, n_checks = 0, nld = 0, side = 0, off = 0, hp = 0, cf = 0;
	bit rec = 1'b0;
	always #12.5 i_clk = ~i_clk;
	joint_homing_sequencer dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address), .i_read(i_read),
		.i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
		.i_home_sw(home_sw), .i_index(index), .i_limit(i_limit), .i_machine_on(i_machine_on),
		.i_stopped(stopped), .i_unlocked(unlocked), .i_joint_pos(joint_pos), .i_home_all(i_home_all),
		.i_lower_homed(i_lower_homed), .o_vel_cmd(o_vel_cmd), .o_pos_load(o_pos_load),
		.o_pos_load_value(o_pos_load_value), .o_limit_masked(o_limit_masked), .o_unlock(o_unlock),
		.o_homing(o_homing), .o_homed(o_homed), .o_error(o_error));
	joint_drive_model drv (.i_clk(i_clk), .i_resetn(i_resetn), .i_vel(o_vel_cmd), .i_load(o_pos_load),
		.i_load_value(o_pos_load_value), .i_unlock(o_unlock), .i_slow(slow), .o_home_sw(home_sw),
		.o_index(index), .o_stopped(stopped), .o_unlocked(unlocked), .o_pos(joint_pos));
	// velocity phases are logged without repeats and without the stops between them
	always @(posedge i_clk) begin
		if (o_pos_load === 1'b1) begin
			nld = nld + 1;
			ld = o_pos_load_value;
		end
		if (rec && o_vel_cmd !== 16'sh0) begin
			if (qg.size() == 0 || qg[$] !== 32'(o_vel_cmd))
				qg.push_back(32'(o_vel_cmd));
			if (o_unlock !== cf[4] || o_limit_masked !== cf[1])
				side = side + 1;
		end
	end
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		i_address <= a;
		i_write <= w;
		i_read <= !w;
		i_writedata <= d;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 40);
		rd = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
		@(posedge i_clk);
		if (n >= 40) begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic settle();
		int n;
		n = 0;
		repeat (6) @(posedge i_clk);
		while (o_homing !== 1'b0 && n < 4000) begin
			@(posedge i_clk);
			n++;
		end
		if (n >= 4000) begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic setup(input int c, input int s, input int l, input int f, input int p);
		cf = c;
		bus(joint_homing_pkg::REG_CFG, 1'b1, c);
		bus(joint_homing_pkg::REG_SEEK_VEL, 1'b1, s);
		bus(joint_homing_pkg::REG_CAPTURE_VEL, 1'b1, l);
		bus(joint_homing_pkg::REG_FINAL_VEL, 1'b1, f);
		bus(joint_homing_pkg::REG_HOME_OFFSET, 1'b1, off);
		bus(joint_homing_pkg::REG_HOME_POS, 1'b1, hp);
		@(negedge i_clk) drv.phys = p;
		@(posedge i_clk);
	endtask
	task automatic run(input int c, s, l, f, p, input bit lim);
		bit bad;
		off = int'($urandom % 400) - 200;
		hp = off + ((($urandom % 2) != 0) ? 150 : -150);
		bad = (s == 0) ? (c[0] != (l != 0)) : (l == 0 || (c[2] && p >= 600 && p <= 900) || (lim && !c[1]));
		qe = {};
		if (s != 0) begin
			if (p >= 600 && p <= 900)
				qe.push_back(-s);
			qe.push_back(s);
			if ((s > 0) == (l > 0))
				qe.push_back(-s);
		end
		if (s != 0 || l != 0) begin
			qe.push_back(l);
			qe.push_back((hp > off ? 1 : -1) * (f != 0 ? f : 20));
		end
		setup(c, s, l, f, p);
		qg = {};
		nld = 0;
		side = 0;
		i_limit <= lim;
		rec = 1'b1;
		bus(joint_homing_pkg::REG_CTRL, 1'b1, 32'h1);
		@(posedge i_clk);
		chk(o_homing, !(c[2] && p >= 600 && p <= 900));
		settle();
		rec = 1'b0;
		i_limit <= 1'b0;
		if (bad) begin
			chk(o_error, 1'b1);
			chk(o_homed, 1'b0);
		end else begin
			chk(nld, 1);
			chk(ld, off);
			chk(o_homed, 1'b1);
			chk(side, 0);
			chk(qg.size(), qe.size());
			foreach (qe[i]) chk(qg[i], qe[i]);
		end
	endtask
	initial begin
		int i;
		i = $urandom(32'haf12df6a);
		repeat (20) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		bus(joint_homing_pkg::REG_CFG, 1'b0, 32'h0);
		chk(rd & 32'hffff, 32'hff00);
		bus(joint_homing_pkg::REG_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h0);
		bus(4'hf, 1'b1, 32'h5a5a5a5a);
		bus(4'hf, 1'b0, 32'h0);
		chk(rd, 32'h0);
		bus(joint_homing_pkg::REG_SEEK_VEL, 1'b1, 32'h0000fff0);
		bus(joint_homing_pkg::REG_SEEK_VEL, 1'b0, 32'h0);
		chk(rd, 32'hfffffff0);
		bus(joint_homing_pkg::REG_MAX_VEL, 1'b1, 32'h14);
		run(0, 0, 0, 0, 0, 0);
		run(0, 8, 2, 0, 0, 0);
		slow = 1'b1;
		run(32'h10, 8, 3, 5, 700, 0);
		slow = 1'b0;
		run(1, 8, -2, 0, 0, 0);
		run(2, -8, 2, 0, 1200, 1);
		run(1, 0, 3, 0, 0, 0);
		run(8, 0, 0, 0, 0, 0);
		i_machine_on <= 1'b0;
		repeat (8) @(posedge i_clk);
		chk(o_homed, 1'b0);
		i_machine_on <= 1'b1;
		repeat (4) @(posedge i_clk);
		run(0, 8, 0, 0, 0, 0);
		run(1, 0, 0, 0, 0, 0);
		run(0, 0, 3, 0, 0, 0);
		run(4, 8, 2, 0, 700, 0);
		run(0, 8, 2, 0, 0, 1);
		setup(0, 0, 0, 0, 0);
		nld = 0;
		i_home_all <= 1'b1;
		@(posedge i_clk);
		i_home_all <= 1'b0;
		repeat (20) @(posedge i_clk);
		chk(nld, 0);
		i_lower_homed <= 1'b1;
		repeat (20) @(posedge i_clk);
		chk(nld, 1);
		setup(32'hff00, 0, 0, 0, 0);
		i_home_all <= 1'b1;
		@(posedge i_clk);
		i_home_all <= 1'b0;
		repeat (20) @(posedge i_clk);
		chk(nld, 1);
		conclude();
	end
endmodule
`default_nettype wire
